/* File: rtl/ube_pkg.sv */
package ube_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map and field layout
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEED = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_PRE_LEN = 8'h0C;
  localparam logic [7:0] REG_PRE_OFF = 8'h10;
  localparam logic [7:0] REG_PAT_ADDR = 8'h14;
  localparam logic [7:0] REG_PAT_DATA = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam int CTRL_START_BIT = 0;
  localparam int MODE_M_LSB = 0;
  localparam int MODE_SCDMA_BIT = 3;
  localparam int MODE_TYPE5_BIT = 4;
  localparam int MODE_PRE_Q1_BIT = 5;
  localparam int MODE_LEG16_BIT = 6;
  localparam int MODE_RATE_LSB = 8;
  localparam logic [14:0] SEED_RST = 15'h7FFF;
  localparam logic [2:0] M_RST = 3'h1;
  localparam logic [2:0] RATE_RST = 3'h5;

  ////////////////////////////////////////////////////////////////////////
  // Preamble store and limits
  localparam int PAT_WORDS = 96;
  localparam int PAT_W = 16;
  localparam logic [10:0] PRE_MAX_T5 = 11'h600;
  localparam logic [10:0] PRE_MAX_T4 = 11'h400;
  localparam logic [2:0] PRE_BITS_QPSK = 3'h2;
  localparam logic [2:0] PRE_BITS_QAM16 = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Trellis and queue sizing
  localparam logic [1:0] NT_M1 = 2'h3;
  localparam logic [1:0] NT_M2 = 2'h2;
  localparam int QW = 32;
  localparam logic [5:0] QROOM = 6'h18;

  ////////////////////////////////////////////////////////////////////////
  // Symbol rate: rate code n gives 160 ksym/s shifted left by n
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [16:0] CLK_KHZ = 17'(1000000 / CLK_PERIOD_NS);
  localparam logic [15:0] RATE_BASE_KSYM = 16'h00A0;
  localparam logic [2:0] RATE_MAX_CODE = 3'h5;
  localparam logic [2:0] RATE_SCDMA_MIN = 3'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_DATA = 2'b11
  } ube_state_type;

  typedef enum logic [2:0] {
    qpsk_constellation_zero = 3'h0,
    qpsk_constellation_one = 3'h1,
    con_qam8 = 3'h2,
    con_qam16 = 3'h3,
    con_qam32 = 3'h4,
    con_qam64 = 3'h5,
    con_qam128 = 3'h6
  } ube_const_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ube_bus_req_type;

  typedef struct packed {
    logic [6:0] label;
    ube_const_type con;
    logic preamble;
    logic last;
  } ube_sym_type;

endpackage

/* File: rtl/ube_encoder.sv */
// Function
// [RULE1] Scrambler seed is fully programmable, 15 bits
// [RULE2] Burst start clears then loads seed
// [RULE3] Scrambler polynomial x15 + x14 + 1
// [RULE4] Seed reloaded from descriptor-configured register
// [RULE5] Code-division mode supports m of 1 to 6
// [RULE6] Eight-state systematic coder adds bit s0
// [RULE7] m of 1 forces i2 to zero
// [RULE8] Coder starts and ends in zero state
// [RULE9] m of 1: three tail symbols, i1=s1
// [RULE10] m of 2: tails (0,s1) then (s2,s1)
// [RULE11] m>=3: uncoded info or zeros, 0-2 tails
// [RULE12] Whole bytes coded or uncoded, shortest burst
// [RULE13] Bytes fed MSB first into label bits
// [RULE14] Return-to-zero bits follow coded data, zero fill
// [RULE15] Preamble prepended ahead of coded data
// [RULE16] First preamble bit chosen by start offset
// [RULE17] Type 5: QPSK variants, even length to 1536
// [RULE18] Type 4 QPSK: variant zero, to 1024
// [RULE19] Type 4 16QAM: multiple of four, to 1024
// [RULE20] Preamble length and pattern from descriptor registers
// [RULE21] Time-division rates 160 to 5120 ksym/s
// [RULE22] Code-division rates 1280 to 5120 ksym/s only
// [RULE23] Fifteen-stage shift register, taps fourteen and fifteen
`timescale 1ns/1ps
module ube_encoder
  import ube_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire ube_bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic in_last,
  output logic in_ready,
  output logic sym_valid,
  output ube_sym_type sym
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Scramble one byte MSB first; returns {next register, byte}
  function automatic logic [22:0] ube_scramble(input logic [14:0] st, input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] o;
    logic fb;
    s = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      // [RULE3] taps x15 and x14
      fb = s[13] ^ s[14];
      o[i] = d[i] ^ fb;
      s = {s[13:0], fb};
    end
    return {s, o};
  endfunction

  // Symbols needed for c coded and u uncoded bits, tails included
  function automatic logic [15:0] ube_cost(input logic [15:0] c, input logic [15:0] u, input logic [2:0] k);
    logic [15:0] cs;
    logic [15:0] us;
    cs = 16'((c + 16'h0001) >> 1) + ((c != 16'h0000) ? 16'(NT_M2) : 16'h0000);
    unique case (k)
      3'h1: us = u;
      3'h2: us = 16'((u + 16'h0001) >> 1);
      3'h3: us = 16'((u + 16'h0002) / 16'h0003);
      default: us = 16'((u + 16'h0003) >> 2);
    endcase
    return (cs > us) ? cs : us;
  endfunction

  // Constellation for a label of n bits
  function automatic ube_const_type ube_con(input logic [2:0] n);
    unique case (n)
      3'h3: return con_qam8;
      3'h4: return con_qam16;
      3'h5: return con_qam32;
      3'h6: return con_qam64;
      3'h7: return con_qam128;
      default: return qpsk_constellation_zero;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  ube_state_type state_r;
  logic [14:0] seed_r;
  logic [10:0] pre_len_r;
  logic [10:0] pre_off_r;
  logic [2:0] m_r;
  logic scdma_r;
  logic type5_r;
  logic pre_q1_r;
  logic leg16_r;
  logic [2:0] rate_r;
  logic [6:0] pat_addr_r;
  logic [PAT_W-1:0] pat_mem [0:PAT_WORDS-1];
  logic [14:0] lfsr_r;
  logic [2:0] tcm_r;
  logic [QW-1:0] cq_r;
  logic [QW-1:0] uq_r;
  logic [5:0] cq_cnt_r;
  logic [5:0] uq_cnt_r;
  logic [15:0] ctot_r;
  logic [15:0] utot_r;
  logic in_done_r;
  logic [1:0] tail_r;
  logic [10:0] pre_cnt_r;
  logic [15:0] acc_r;
  logic [15:0] sym_cnt_r;
  logic start;
  logic tick;
  logic [16:0] acc_sum;
  logic [2:0] rate_eff;
  logic [2:0] m_eff;
  logic legacy;
  logic [10:0] pre_max;
  logic [10:0] eff_len;
  logic [2:0] pb;
  logic [3:0] pre_bits;
  logic [2:0] ku;
  logic [1:0] cb;
  logic to_coded;
  logic in_fire;
  logic [22:0] scr;
  logic c_have;
  logic use_cdata;
  logic use_tail;
  logic go;
  logic i2;
  logic i1;
  logic [5:0] cpop;
  logic [5:0] upop;
  logic [6:0] unc7;
  logic [1:0] tail_nxt;
  logic is_last;

  ////////////////////////////////////////////////////////////////////////
  // Register writes; start only honoured while idle
  assign start = bus_req.wr && (bus_req.addr == REG_CTRL) && bus_req.wdata[CTRL_START_BIT] && (state_r == ST_IDLE);

  // Descriptor-derived configuration
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seed_r <= SEED_RST;
      pre_len_r <= '0;
      pre_off_r <= '0;
      m_r <= M_RST;
      scdma_r <= 1'b0;
      type5_r <= 1'b1;
      pre_q1_r <= 1'b0;
      leg16_r <= 1'b0;
      rate_r <= RATE_RST;
      pat_addr_r <= '0;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        // [RULE1] any seed value accepted
        REG_SEED: seed_r <= bus_req.wdata[14:0];
        // [RULE20] length and offset from descriptor
        REG_PRE_LEN: pre_len_r <= bus_req.wdata[10:0];
        REG_PRE_OFF: pre_off_r <= bus_req.wdata[10:0];
        REG_MODE: begin
          m_r <= bus_req.wdata[MODE_M_LSB +: 3];
          scdma_r <= bus_req.wdata[MODE_SCDMA_BIT];
          type5_r <= bus_req.wdata[MODE_TYPE5_BIT];
          pre_q1_r <= bus_req.wdata[MODE_PRE_Q1_BIT];
          leg16_r <= bus_req.wdata[MODE_LEG16_BIT];
          rate_r <= bus_req.wdata[MODE_RATE_LSB +: 3];
        end
        REG_PAT_ADDR: pat_addr_r <= bus_req.wdata[6:0];
        REG_PAT_DATA: pat_addr_r <= pat_addr_r + 7'h01;
        default: pat_addr_r <= pat_addr_r;
      endcase
    end
  end

  // Pattern store; no reset, software loads it before use
  always_ff @(posedge clock) begin
    if (bus_req.wr && (bus_req.addr == REG_PAT_DATA) && (32'(pat_addr_r) < PAT_WORDS)) begin
      pat_mem[pat_addr_r] <= bus_req.wdata[PAT_W-1:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= '0;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        REG_SEED: bus_rdata <= 32'(seed_r);
        REG_PRE_LEN: bus_rdata <= 32'(pre_len_r);
        REG_PRE_OFF: bus_rdata <= 32'(pre_off_r);
        REG_MODE: bus_rdata <= 32'({rate_r, 1'b0, leg16_r, pre_q1_r, type5_r, scdma_r, m_r});
        REG_PAT_ADDR: bus_rdata <= 32'(pat_addr_r);
        REG_STATUS: bus_rdata <= {sym_cnt_r, 9'h000, tcm_r, in_done_r, state_r, (state_r != ST_IDLE)};
        default: bus_rdata <= '0;
      endcase
    end else begin
      bus_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Symbol rate pacing
  // [RULE21] six rates, clamped to the top code
  // [RULE22] code-division mode floors the rate code
  always_comb begin
    rate_eff = (rate_r > RATE_MAX_CODE) ? RATE_MAX_CODE : rate_r;
    if (scdma_r && (rate_eff < RATE_SCDMA_MIN)) begin
      rate_eff = RATE_SCDMA_MIN;
    end
  end
  // Fractional accumulator keeps the average rate exact at 25 MHz
  assign acc_sum = {1'b0, acc_r} + {1'b0, RATE_BASE_KSYM << rate_eff};
  assign tick = (acc_sum >= CLK_KHZ);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= '0;
    end else if (start) begin
      acc_r <= '0;
    end else begin
      acc_r <= tick ? 16'(acc_sum - CLK_KHZ) : acc_sum[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Preamble length limits and bit fetch
  assign legacy = !type5_r;
  assign pre_max = legacy ? PRE_MAX_T4 : PRE_MAX_T5;
  // [RULE17] [RULE18] even length, capped per descriptor type
  // [RULE19] legacy 16QAM length drops to a multiple of four
  assign eff_len = ((pre_len_r > pre_max) ? pre_max : pre_len_r) & ((legacy && leg16_r) ? ~11'h003 : ~11'h001);
  assign pb = (legacy && leg16_r) ? PRE_BITS_QAM16 : PRE_BITS_QPSK;

  // [RULE16] pattern read starts at the programmed offset
  always_comb begin
    logic [10:0] b;
    b = '0;
    for (int j = 0; j < 4; j++) begin
      b = pre_off_r + pre_cnt_r + 11'(j);
      pre_bits[3-j] = (32'(b[10:4]) < PAT_WORDS) ? pat_mem[b[10:4]][~b[3:0]] : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Label geometry and byte steering
  // [RULE5] m outside 1..6 is clamped
  assign m_eff = (m_r == 3'h0) ? 3'h1 : ((m_r == 3'h7) ? 3'h6 : m_r);
  assign ku = scdma_r ? ((m_eff >= 3'h3) ? 3'(m_eff - 3'h2) : 3'h0) : 3'(m_eff + 3'h1);
  assign cb = scdma_r ? ((m_eff == 3'h1) ? 2'h1 : 2'h2) : 2'h0;

  // [RULE12] byte goes where the burst would end soonest; ties go coded
  assign to_coded = (cb != 2'h0) && ((ku == 3'h0) ||
    (ube_cost(ctot_r + 16'h0008, utot_r, ku) <= ube_cost(ctot_r, utot_r + 16'h0008, ku)));
  // Back-pressure: the target queue must have room for a whole byte
  assign in_ready = (state_r == ST_DATA) && !in_done_r && (to_coded ? (cq_cnt_r <= QROOM) : (uq_cnt_r <= QROOM));
  assign in_fire = in_valid && in_ready;
  // [RULE23] scramble each byte before it is queued
  assign scr = ube_scramble(lfsr_r, in_byte);

  ////////////////////////////////////////////////////////////////////////
  // Symbol assembly
  assign c_have = (cb != 2'h0) && (cq_cnt_r >= 6'(cb));
  assign use_cdata = c_have;
  assign use_tail = !c_have && in_done_r && (tail_r != 2'h0);
  // Mid-burst the coder waits for both streams; at the end it drains
  assign go = tick && (state_r == ST_DATA) && (in_done_r ? ((cq_cnt_r != 6'h00) || (tail_r != 2'h0) ||
    (uq_cnt_r != 6'h00)) : (((cb == 2'h0) || c_have) && (uq_cnt_r >= 6'(ku))));

  always_comb begin
    i2 = 1'b0;
    i1 = 1'b0;
    if (use_cdata) begin
      // [RULE13] first queued bit lands on i2, or on i1 when m is 1
      if (cb == 2'h1) begin
        i1 = cq_r[QW-1];
      end else begin
        i2 = cq_r[QW-1];
        i1 = cq_r[QW-2];
      end
    end else if (use_tail) begin
      // [RULE9] [RULE10] tail inputs from state bits
      i1 = tcm_r[1];
      i2 = (cb == 2'h2) && (tail_r == 2'h1) ? tcm_r[2] : 1'b0;
    end
    // [RULE7] rate one-half coding keeps i2 at zero
    if (cb == 2'h1) begin
      i2 = 1'b0;
    end
  end

  // [RULE13] uncoded bits leave MSB first toward the top label bit
  assign unc7 = uq_r[QW-1 -: 7] >> (3'h7 - ku);
  assign cpop = use_cdata ? 6'(cb) : 6'h00;
  // [RULE11] short uncoded field is zero filled at the end
  assign upop = (uq_cnt_r < 6'(ku)) ? uq_cnt_r : 6'(ku);
  // [RULE14] tails directly after coded data, then zeros
  assign tail_nxt = use_tail ? 2'(tail_r - 2'h1) : tail_r;
  assign is_last = in_done_r && (cq_cnt_r == cpop) && (tail_nxt == 2'h0) && (uq_cnt_r == upop);

  ////////////////////////////////////////////////////////////////////////
  // Burst sequencer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      pre_cnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          pre_cnt_r <= '0;
          if (start) begin
            state_r <= (eff_len != 11'h000) ? ST_PRE : ST_DATA;
          end
        end
        // [RULE15] preamble symbols go out before any data
        ST_PRE: begin
          if (tick) begin
            pre_cnt_r <= 11'(pre_cnt_r + 11'(pb));
            if (11'(pre_cnt_r + 11'(pb)) >= eff_len) begin
              state_r <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (go && is_last) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // [RULE2] [RULE4] register cleared, then seed loaded at burst start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lfsr_r <= '0;
    end else if (start) begin
      lfsr_r <= seed_r;
    end else if (in_fire) begin
      lfsr_r <= scr[22:8];
    end
  end

  // [RULE6] [RULE8] eight-state coder, zeroed at start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tcm_r <= '0;
    end else if (start) begin
      tcm_r <= '0;
    end else if (go && scdma_r) begin
      tcm_r <= {tcm_r[0], tcm_r[2] ^ i2, tcm_r[1] ^ i1};
    end
  end

  // Bit queues: pop by the symbol, push a whole byte behind what remains
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cq_r <= '0;
      uq_r <= '0;
      cq_cnt_r <= '0;
      uq_cnt_r <= '0;
    end else if (start) begin
      cq_r <= '0;
      uq_r <= '0;
      cq_cnt_r <= '0;
      uq_cnt_r <= '0;
    end else begin
      logic [QW-1:0] cq_a;
      logic [QW-1:0] uq_a;
      logic [5:0] cc_a;
      logic [5:0] uc_a;
      cq_a = go ? (cq_r << cpop) : cq_r;
      uq_a = go ? (uq_r << upop) : uq_r;
      cc_a = go ? 6'(cq_cnt_r - cpop) : cq_cnt_r;
      uc_a = go ? 6'(uq_cnt_r - upop) : uq_cnt_r;
      // [RULE12] a byte lands wholly in one queue
      if (in_fire && to_coded) begin
        cq_a = cq_a | ({scr[7:0], {(QW-8){1'b0}}} >> cc_a);
        cc_a = 6'(cc_a + 6'h08);
      end else if (in_fire) begin
        uq_a = uq_a | ({scr[7:0], {(QW-8){1'b0}}} >> uc_a);
        uc_a = 6'(uc_a + 6'h08);
      end
      cq_r <= cq_a;
      uq_r <= uq_a;
      cq_cnt_r <= cc_a;
      uq_cnt_r <= uc_a;
    end
  end

  // Burst totals, end-of-input flag and tail budget
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctot_r <= '0;
      utot_r <= '0;
      in_done_r <= 1'b0;
      tail_r <= '0;
    end else if (start) begin
      ctot_r <= '0;
      utot_r <= '0;
      in_done_r <= 1'b0;
      tail_r <= '0;
    end else if (in_fire) begin
      if (to_coded) begin
        ctot_r <= 16'(ctot_r + 16'h0008);
      end else begin
        utot_r <= 16'(utot_r + 16'h0008);
      end
      if (in_last) begin
        in_done_r <= 1'b1;
        // [RULE9] [RULE10] [RULE11] tails only when coded data was sent
        tail_r <= (!to_coded && (ctot_r == 16'h0000)) ? 2'h0 : ((cb == 2'h1) ? NT_M1 : NT_M2);
      end
    end else if (go) begin
      tail_r <= tail_nxt;
    end
  end

  // Output symbol register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sym_valid <= 1'b0;
      sym <= '0;
      sym_cnt_r <= '0;
    end else begin
      sym_valid <= 1'b0;
      if (start) begin
        sym_cnt_r <= '0;
      end
      if ((state_r == ST_PRE) && tick) begin
        sym_valid <= 1'b1;
        sym_cnt_r <= 16'(sym_cnt_r + 16'h0001);
        sym.label <= (pb == PRE_BITS_QAM16) ? {3'h0, pre_bits} : {5'h00, pre_bits[3:2]};
        // [RULE17] [RULE18] [RULE19] preamble constellation per descriptor
        sym.con <= legacy ? (leg16_r ? con_qam16 : qpsk_constellation_zero)
                          : (pre_q1_r ? qpsk_constellation_one : qpsk_constellation_zero);
        sym.preamble <= 1'b1;
        sym.last <= 1'b0;
      end else if (go) begin
        sym_valid <= 1'b1;
        sym_cnt_r <= 16'(sym_cnt_r + 16'h0001);
        // [RULE6] label is uncoded bits, i2, i1 and coded bit s0
        sym.label <= scdma_r ? {unc7[3:0], i2, i1, tcm_r[0]} : unc7;
        sym.con <= ube_con(3'(m_eff + 3'h1));
        sym.preamble <= 1'b0;
        sym.last <= is_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic data_seen_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_seen_r <= 1'b0;
    end else if (start) begin
      data_seen_r <= 1'b0;
    end else if (sym_valid && !sym.preamble) begin
      data_seen_r <= 1'b1;
    end
  end

  default clocking cb_main @(posedge clock); endclocking
  default disable iff (!rst_b);

  seed_load_a: assert property (start |=> lfsr_r == $past(seed_r)) // [RULE2]
    else $error("scrambler not loaded with seed at burst start");
  tcm_start_a: assert property (start |=> tcm_r == 3'h0) // [RULE8]
    else $error("coder not zeroed at burst start");
  tcm_end_a: assert property (sym_valid && sym.last && scdma_r |-> tcm_r == 3'h0) // [RULE8]
    else $error("coder not in zero state after last symbol");
  coded_bit_a: assert property (sym_valid && !sym.preamble && scdma_r |-> sym.label[0] == tcm_r[2]) // [RULE6]
    else $error("coded bit differs from lowest state bit");
  half_rate_a: assert property (sym_valid && !sym.preamble && scdma_r && m_eff == 3'h1
    |-> sym.label[6:2] == 5'h00) // [RULE7]
    else $error("upper label bits set at rate one-half");
  scdma_rate_a: assert property (scdma_r |-> rate_eff >= RATE_SCDMA_MIN && rate_eff <= RATE_MAX_CODE) // [RULE22]
    else $error("code-division rate out of range");
  pre_len_a: assert property (state_r == ST_PRE |-> pre_cnt_r < eff_len && eff_len <= pre_max) // [RULE17]
    else $error("preamble ran past its length");
  leg16_len_a: assert property (legacy && leg16_r |-> eff_len[1:0] == 2'h0) // [RULE19]
    else $error("legacy 16QAM preamble not a multiple of four");
  pre_first_a: assert property (sym_valid && sym.preamble |-> !data_seen_r) // [RULE15]
    else $error("preamble symbol after data symbol");
  tail_len_a: assert property (in_fire && in_last && cb == 2'h1 |=> tail_r == 2'h3 [*1] ##1 1'b1) // [RULE9]
    else $error("three tails not scheduled for m of one");

  pre_burst_c: cover property (start ##1 state_r == ST_PRE ##[1:1000] state_r == ST_DATA);
  m1_end_c: cover property (sym_valid && sym.last && scdma_r && m_eff == 3'h1);
  m6_end_c: cover property (sym_valid && sym.last && scdma_r && m_eff == 3'h6);
  tdma_end_c: cover property (sym_valid && sym.last && !scdma_r);

endmodule

/* File: sim/ube_mac_model.sv */
`timescale 1ns/1ps
module ube_mac_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] val,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_byte,
  output logic in_last
);
  logic [4:0] dly_r;
  logic pend_r;

  // One-byte burst feeder; slow mode stalls 20 cycles before offering
  // Byte is held until taken, then the data lines show the inverse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dly_r <= 5'h00;
      pend_r <= 1'b0;
      in_valid <= 1'b0;
      in_byte <= 8'h00;
      in_last <= 1'b0;
    end else if (go) begin
      pend_r <= 1'b1;
      dly_r <= slow ? 5'h14 : 5'h00;
    end else if (pend_r && dly_r != 5'h00) begin
      dly_r <= dly_r - 5'h01;
    end else if (pend_r && !in_valid) begin
      in_valid <= 1'b1;
      in_byte <= val;
      in_last <= 1'b1;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      pend_r <= 1'b0;
      in_byte <= ~in_byte;
      in_last <= 1'b0;
    end
  end
endmodule

/* File: sim/upstream_burst_encoder_tb_top.sv */
`timescale 1ns/1ps
module upstream_burst_encoder_tb_top
  import ube_pkg::*;
();
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  ube_bus_req_type bus_req = '0;
  logic [31:0] bus_rdata, rv;
  logic in_valid, in_ready, in_last, sym_valid, go = 1'b0, slow = 1'b0;
  logic [7:0] in_byte, val = 8'h00;
  ube_sym_type sym;
  ube_sym_type q[$];
  logic [6:0] el[$];
  logic [14:0] lf;
  logic [2:0] s;
  logic [7:0] db;
  int err_count = 0, n_tests = 0, k;

  always #20 clock = ~clock;

  ube_encoder uut (.clock(clock), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .in_valid(in_valid), .in_byte(in_byte), .in_last(in_last), .in_ready(in_ready),
    .sym_valid(sym_valid), .sym(sym));
  ube_mac_model mac (.clock(clock), .rst_b(rst_b), .go(go), .slow(slow), .val(val),
    .in_ready(in_ready), .in_valid(in_valid), .in_byte(in_byte), .in_last(in_last));

  // Symbol pulses last one cycle, so capture every one mid-cycle, clear of the launching edge
  always @(negedge clock) if (sym_valid === 1'b1) q.push_back(sym);

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task final_report;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock) bus_req.wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock) bus_req.rd <= 1'b0;
    @(negedge clock) d = bus_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reference scrambler: taps 14 and 15, output folded onto data
  function automatic logic scr(input logic d);
    logic fb;
    fb = lf[13] ^ lf[14];
    lf = {lf[13:0], fb};
    return d ^ fb;
  endfunction

  // Reference coder step: x1 is s0, next state {s0, s2^i2, s1^i1}
  task tr(input logic m2, input logic i2, input logic i1);
    el.push_back(m2 ? {4'h0, i2, i1, s[0]} : {5'h0, i1, s[0]});
    s = {s[0], s[2] ^ i2, s[1] ^ i1};
  endtask

  // Two coded bits a symbol, first bit on i2, then both tail symbols
  task tc2(input logic [7:0] b);
    logic c2;
    for (int i = 0; i < 4; i++) begin
      c2 = scr(b[7 - 2 * i]);
      tr(1'b1, c2, scr(b[6 - 2 * i]));
    end
    tr(1'b1, 1'b0, s[1]);
    tr(1'b1, s[2], s[1]);
  endtask

  task td(input int w, input logic [7:0] b);
    logic [6:0] l;
    l = '0;
    for (int i = 0; i < 8; i++) begin
      l = {l[5:0], scr(b[7-i])};
      if (i % w == w - 1) begin
        el.push_back(l);
        l = '0;
      end
    end
  endtask

  task prep;
    el.delete();
    lf = 15'h5A5A;
    s = 3'h0;
  endtask

  // Run one burst, wait for idle, compare labels and ending
  task burst(input logic [31:0] mode, input logic [7:0] b);
    q.delete();
    val <= b;
    wr(REG_MODE, mode);
    wr(REG_CTRL, 32'h1);
    go <= 1'b1;
    @(posedge clock) go <= 1'b0;
    rv = 32'h1;
    for (k = 0; k < 3000 && rv[0] !== 1'b0; k++) rd(REG_STATUS, rv);
    chk({31'h0, rv[0]}, 32'h0);
    chk(32'(q.size()), 32'(el.size()));
    foreach (el[i]) if (i < q.size()) chk({25'h0, q[i].label}, {25'h0, el[i]});
    chk({31'h0, q[$].last}, 32'h1);
    chk({29'h0, rv[6:4]}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    #2000000;
    err_count++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    rd(REG_SEED, rv);
    chk(rv, 32'h7FFF);
    chk({31'h0, in_ready}, 32'h0);
    rd(REG_MODE, rv);
    chk(rv, 32'h511);
    rd(REG_CTRL, rv);
    chk(rv, 32'h0);
    rd(8'hFC, rv);
    chk(rv, 32'h0);
    wr(REG_SEED, 32'h5A5A);
    rd(REG_SEED, rv);
    chk(rv, 32'h5A5A);
    wr(REG_PAT_ADDR, 32'h0);
    wr(REG_PAT_DATA, 32'hB400);
    wr(REG_PRE_LEN, 32'h4);
    wr(REG_PRE_OFF, 32'h2);
    // Offset 2 of 1011_0100 gives preamble 11 then 01
    prep();
    el.push_back(7'h3);
    el.push_back(7'h1);
    td(2, 8'h00);
    burst(32'h531, 8'h00);
    chk({31'h0, q[0].preamble}, 32'h1);
    chk({29'h0, q[0].con}, {29'h0, qpsk_constellation_one});
    chk({31'h0, q[2].preamble}, 32'h0);
    // Same seed again proves the scrambler restarts per burst
    wr(REG_PRE_LEN, 32'h0);
    prep();
    td(2, 8'hFF);
    burst(32'h511, 8'hFF);
    // Code-division, one bit per symbol, three tails
    prep();
    db = 8'hA5;
    for (int i = 0; i < 8; i++) tr(1'b0, 1'b0, scr(db[7 - i]));
    for (int i = 0; i < 3; i++) tr(1'b0, 1'b0, s[1]);
    burst(32'h519, 8'hA5);
    // Code-division, two bits per symbol, slow feeder, two tails
    prep();
    slow <= 1'b1;
    tc2(8'h3C);
    burst(32'h51A, 8'h3C);
    slow <= 1'b0;
    // Code-division, m of 3: a lone byte goes coded, uncoded bit zero filled
    prep();
    tc2(8'h5E);
    burst(32'h51B, 8'h5E);
    chk({29'h0, q[0].con}, {29'h0, con_qam16});
    // Legacy 16QAM: four-bit preamble symbols, pattern from offset 0
    wr(REG_PRE_LEN, 32'h8);
    wr(REG_PRE_OFF, 32'h0);
    prep();
    el.push_back(7'hB);
    el.push_back(7'h4);
    td(4, 8'h96);
    burst(32'h543, 8'h96);
    chk({29'h0, q[0].con}, {29'h0, con_qam16});
    chk({29'h0, q[2].con}, {29'h0, con_qam16});
    final_report();
  end
endmodule
